// ---- rtl/supply_fault_pkg.sv ----
`default_nettype none
package supply_fault_pkg;
	// Channel layout: 0 high voltage, 1..4 positive supply, 5..9 dual function
	localparam int NUM_CH   = 10;
	localparam int NUM_DED  = 5;
	localparam int NUM_DUAL = 5;
	localparam int MV_W     = 16;
	localparam int CODE_W   = 8;
	localparam int HYST_W   = 5;
	localparam int RNG_W    = 2;
	localparam int FILT_W   = 3;
	localparam int CNT_W    = 12;

	// Threshold scale and hysteresis limit
	localparam logic [7:0] CODE_FULL_SCALE = 8'hff;
	localparam logic [4:0] HYST_CODE_MAX   = 5'h1f;

	// Range bottoms and spans in millivolts
	localparam logic [15:0] RANGE_BOTTOM_MV [4] = '{16'h023d, 16'h04e2, 16'h09c4, 16'h1770};
	localparam logic [15:0] RANGE_SPAN_MV   [4] = '{16'h0322, 16'h06d6, 16'h0dac, 16'h20d0};
	localparam logic [1:0]  RANGE_LOW     = 2'h0;
	localparam logic [1:0]  RANGE_MID     = 2'h2;
	localparam logic [1:0]  RANGE_HIGH_HV = 2'h3;

	// Detector modes
	typedef enum logic [1:0] {
		MODE_OFF    = 2'h0,
		MODE_UV     = 2'h1,
		MODE_OV     = 2'h2,
		MODE_WINDOW = 2'h3
	} det_mode_t;

	// Glitch filter timing
	localparam int CLK_HZ        = 20000000;
	localparam int GLITCH_MAX_US = 100;
	localparam int GLITCH_US [8] = '{0, 5, 10, 20, 30, 50, 75, GLITCH_MAX_US};

	function automatic logic [CNT_W-1:0] glitch_limit(input logic [2:0] code);
		return CNT_W'(GLITCH_US[code] * (CLK_HZ / 1000000));
	endfunction

	// Channel configuration word fields
	localparam int CFG_UV_LSB     = 0;
	localparam int CFG_OV_LSB     = 8;
	localparam int CFG_HYST_LSB   = 16;
	localparam int CFG_MODE_LSB   = 21;
	localparam int CFG_RANGE_LSB  = 23;
	localparam int CFG_FILT_LSB   = 25;
	localparam int CFG_ANALOG_BIT = 28;
	localparam logic [31:0] CFG_MASK  = 32'h1fff_ffff;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;

	// Register offsets
	localparam logic [11:0] ADDR_CFG_BASE = 12'h000;
	localparam logic [11:0] ADDR_CFG_END  = 12'h028;
	localparam logic [11:0] ADDR_FAULT    = 12'h040;
	localparam logic [11:0] ADDR_UV       = 12'h044;
	localparam logic [11:0] ADDR_OV       = 12'h048;
	localparam logic [11:0] ADDR_WARN     = 12'h04c;
	localparam logic [11:0] ADDR_LOGIC    = 12'h050;
endpackage
`default_nettype wire

// ---- rtl/glitch_filter.sv ----
`timescale 1ns/10ps
`default_nettype none
module glitch_filter #(
	parameter int CW = 12
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          in_i,
	input  wire logic [CW-1:0] limit_i,
	output logic               out_o
);
	logic          out_q, out_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [CW:0]   cnt_next;

	assign cnt_next = {1'b0, cnt_q} + {{CW{1'b0}}, 1'b1};
	assign out_o    = out_q;

	// Change passes only after it has lasted the timeout
	always_comb begin
		out_d = out_q;
		cnt_d = '0;
		if (in_i != out_q) begin
			if (cnt_next >= {1'b0, limit_i}) begin
				out_d = in_i;
			end else begin
				cnt_d = cnt_next[CW-1:0];
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			out_q <= out_d;
			cnt_q <= cnt_d;
		end
	end

	property p_short_held;
		@(posedge clk_i) disable iff (rst_i)
		(in_i != out_q) && (cnt_next < {1'b0, limit_i}) |=> out_q == $past(out_q);
	endproperty
	a_short_held: assert property (p_short_held) else $error("Filter passed short pulse");

	property p_long_passed;
		@(posedge clk_i) disable iff (rst_i)
		(in_i != out_q) && (cnt_next >= {1'b0, limit_i}) |=> out_q == $past(in_i);
	endproperty
	a_long_passed: assert property (p_long_passed) else $error("Filter held long pulse");
endmodule // glitch_filter
`default_nettype wire

// ---- rtl/fault_detector.sv ----
`timescale 1ns/10ps
`default_nettype none
module fault_detector (
	input  wire logic                                  clk_i,
	input  wire logic                                  rst_i,
	input  wire logic [supply_fault_pkg::MV_W-1:0]     volt_i,
	input  wire logic [supply_fault_pkg::CODE_W-1:0]   uv_code_i,
	input  wire logic [supply_fault_pkg::CODE_W-1:0]   ov_code_i,
	input  wire logic [supply_fault_pkg::HYST_W-1:0]   hyst_code_i,
	input  wire supply_fault_pkg::det_mode_t           mode_i,
	input  wire logic [supply_fault_pkg::RNG_W-1:0]    range_i,
	output logic                                       uv_o,
	output logic                                       ov_o
);
	logic        uv_q, uv_d, ov_q, ov_d;
	logic [31:0] v, bot, span, uv_th, ov_th, hyst;
	logic        uv_en, ov_en;

	// Thresholds from codes and range
	always_comb begin
		v     = 32'(volt_i);
		bot   = 32'(supply_fault_pkg::RANGE_BOTTOM_MV[range_i]);
		span  = 32'(supply_fault_pkg::RANGE_SPAN_MV[range_i]);
		uv_th = bot + span * 32'(uv_code_i) / 32'(supply_fault_pkg::CODE_FULL_SCALE);
		ov_th = bot + span * 32'(ov_code_i) / 32'(supply_fault_pkg::CODE_FULL_SCALE);
		hyst  = span * 32'(hyst_code_i) / 32'(supply_fault_pkg::CODE_FULL_SCALE);
	end

	assign uv_en = (mode_i == supply_fault_pkg::MODE_UV) || (mode_i == supply_fault_pkg::MODE_WINDOW);
	assign ov_en = (mode_i == supply_fault_pkg::MODE_OV) || (mode_i == supply_fault_pkg::MODE_WINDOW);
	assign uv_o  = uv_q;
	assign ov_o  = ov_q;

	// Compare every cycle, hysteresis only while a flag stands
	always_comb begin
		uv_d = 1'b0;
		ov_d = 1'b0;
		if (uv_en) begin
			if (!uv_q) begin
				uv_d = v < uv_th;
			end else begin
				uv_d = !(v > uv_th + hyst);
			end
		end
		if (ov_en) begin
			if (!ov_q) begin
				ov_d = v > ov_th;
			end else begin
				ov_d = !(v + hyst < ov_th);
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			uv_q <= 1'b0;
			ov_q <= 1'b0;
		end else begin
			uv_q <= uv_d;
			ov_q <= ov_d;
		end
	end

	property p_uv_set;
		@(posedge clk_i) disable iff (rst_i)
		uv_en && !uv_q && (v < uv_th) |=> uv_q;
	endproperty
	a_uv_set: assert property (p_uv_set) else $error("Undervoltage not flagged");

	property p_uv_hyst;
		@(posedge clk_i) disable iff (rst_i)
		uv_en && uv_q && (v <= uv_th + hyst) |=> uv_q;
	endproperty
	a_uv_hyst: assert property (p_uv_hyst) else $error("Undervoltage cleared inside hysteresis");

	property p_ov_hyst;
		@(posedge clk_i) disable iff (rst_i)
		ov_en && ov_q && (v + hyst >= ov_th) |=> ov_q;
	endproperty
	a_ov_hyst: assert property (p_ov_hyst) else $error("Overvoltage cleared inside hysteresis");

	property p_window;
		@(posedge clk_i) disable iff (rst_i)
		(mode_i == supply_fault_pkg::MODE_WINDOW) && !ov_q && (v > ov_th) |=> ov_q;
	endproperty
	a_window: assert property (p_window) else $error("Window overvoltage missed");

	property p_off;
		@(posedge clk_i) disable iff (rst_i)
		(mode_i == supply_fault_pkg::MODE_OFF) |=> !uv_q && !ov_q;
	endproperty
	a_off: assert property (p_off) else $error("Flag set while detector off");
endmodule // fault_detector
`default_nettype wire

// ---- rtl/supply_fault_monitor.sv ----
// Contract
// - Ten inputs: five dedicated, five dual function
// - Analog dual input gives no logic function
// - Modes: undervoltage, overvoltage or out of window
// - Eight-bit threshold code, step span over 255
// - Threshold equals span times code/255 plus bottom
// - Four ranges with given bottoms and spans
// - High voltage input: two ranges, glitch filter
// - Comparators evaluate continuously, every cycle
// - Undervoltage clears above threshold plus hysteresis
// - Overvoltage clears below threshold minus hysteresis
// - Five-bit hysteresis code, span times code/255
// - Glitch filter suppresses short, delays long pulses
// - Logic-mode dual detector warns on mapped input
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module supply_fault_monitor (
	// Clock and reset
	input  wire logic                    CLK_I,
	input  wire logic                    RST_I,
	// APB slave
	input  wire logic                    PSEL_I,
	input  wire logic                    PENABLE_I,
	input  wire logic                    PWRITE_I,
	input  wire logic [11:0]             PADDR_I,
	input  wire logic [31:0]             PWDATA_I,
	input  wire logic [3:0]              PSTRB_I,
	output logic      [31:0]             PRDATA_O,
	output logic                         PREADY_O,
	output logic                         PSLVERR_O,
	// Monitored rails in millivolts
	input  wire logic [15:0]             HIGH_VOLTAGE_INPUT_MV_I,
	input  wire logic [63:0]             POSITIVE_SUPPLY_INPUT_MV_I,
	input  wire logic [79:0]             DUAL_FUNCTION_INPUT_MV_I,
	input  wire logic [4:0]              DUAL_FUNCTION_LOGIC_I,
	// Fault outputs
	output logic      [9:0]              FAULT_O,
	output logic      [9:0]              UNDERVOLTAGE_FLAG_O,
	output logic      [9:0]              OVERVOLTAGE_FLAG_O,
	output logic      [4:0]              WARNING_O,
	output logic      [4:0]              LOGIC_INPUT_O
);
	localparam int NCH  = supply_fault_pkg::NUM_CH;
	localparam int NDED = supply_fault_pkg::NUM_DED;
	localparam int NDU  = supply_fault_pkg::NUM_DUAL;
	localparam int MW   = supply_fault_pkg::MV_W;

	logic [31:0]    cfg_q [NCH];
	logic [31:0]    cfg_d [NCH];
	logic [31:0]    prdata_q, prdata_d;
	logic           pready_q, pready_d;
	logic           pslverr_q, pslverr_d;
	logic [NCH-1:0] fault_q, fault_d, uvf_q, ovf_q;
	logic [NDU-1:0] warn_q, warn_d, logic_q, logic_d;
	logic [NCH-1:0] uv_filt, ov_filt;
	logic [NCH-1:0] analog_sel;
	logic [MW-1:0]  ded_mv [NDED];
	logic [MW-1:0]  own_mv [NCH];
	logic           cfg_hit, setup, access, addr_known;
	logic [3:0]     cfg_idx;

	// Legal range per channel
	function automatic logic [1:0] eff_range(input int ch, input logic [1:0] r);
		if (ch == 0) begin
			return {1'b1, r[0]};
		end else if (ch < NDED) begin
			return (r == supply_fault_pkg::RANGE_HIGH_HV) ? supply_fault_pkg::RANGE_MID : r;
		end
		return supply_fault_pkg::RANGE_LOW;
	endfunction

	// Rail voltages per channel
	always_comb begin
		ded_mv[0] = HIGH_VOLTAGE_INPUT_MV_I;
		for (int k = 1; k < NDED; k++) begin
			ded_mv[k] = POSITIVE_SUPPLY_INPUT_MV_I[(k-1)*MW +: MW];
		end
		for (int k = 0; k < NDED; k++) begin
			own_mv[k] = ded_mv[k];
		end
		for (int k = NDED; k < NCH; k++) begin
			own_mv[k] = DUAL_FUNCTION_INPUT_MV_I[(k-NDED)*MW +: MW];
		end
	end

	// One detector and two filters per channel
	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			localparam int MAP = (i < NDED) ? i : ((i - NDED < 4) ? i - NDED + 1 : 0);
			logic [MW-1:0]                    volt_sel;
			logic [1:0]                       rng_sel;
			logic                             uv_raw, ov_raw;
			logic [supply_fault_pkg::CNT_W-1:0] lim;

			assign analog_sel[i] = (i < NDED) ? 1'b1 : cfg_q[i][supply_fault_pkg::CFG_ANALOG_BIT];
			// Logic-mode dual channel watches its dedicated partner
			assign volt_sel = analog_sel[i] ? own_mv[i] : ded_mv[MAP];
			assign rng_sel  = analog_sel[i]
				? eff_range(i, cfg_q[i][supply_fault_pkg::CFG_RANGE_LSB +: 2])
				: eff_range(MAP, cfg_q[MAP][supply_fault_pkg::CFG_RANGE_LSB +: 2]);
			assign lim = supply_fault_pkg::glitch_limit(cfg_q[i][supply_fault_pkg::CFG_FILT_LSB +: 3]);

			fault_detector u_det (
				.clk_i       (CLK_I),
				.rst_i       (RST_I),
				.volt_i      (volt_sel),
				.uv_code_i   (cfg_q[i][supply_fault_pkg::CFG_UV_LSB +: 8]),
				.ov_code_i   (cfg_q[i][supply_fault_pkg::CFG_OV_LSB +: 8]),
				.hyst_code_i (cfg_q[i][supply_fault_pkg::CFG_HYST_LSB +: 5]),
				.mode_i      (supply_fault_pkg::det_mode_t'(cfg_q[i][supply_fault_pkg::CFG_MODE_LSB +: 2])),
				.range_i     (rng_sel),
				.uv_o        (uv_raw),
				.ov_o        (ov_raw)
			);

			glitch_filter #(.CW(supply_fault_pkg::CNT_W)) u_uv_filt (
				.clk_i   (CLK_I),
				.rst_i   (RST_I),
				.in_i    (uv_raw),
				.limit_i (lim),
				.out_o   (uv_filt[i])
			);

			glitch_filter #(.CW(supply_fault_pkg::CNT_W)) u_ov_filt (
				.clk_i   (CLK_I),
				.rst_i   (RST_I),
				.in_i    (ov_raw),
				.limit_i (lim),
				.out_o   (ov_filt[i])
			);
		end
	endgenerate

	// Fault, warning and logic outputs
	always_comb begin
		for (int k = 0; k < NCH; k++) begin
			fault_d[k] = analog_sel[k] & (uv_filt[k] | ov_filt[k]);
		end
		for (int k = 0; k < NDU; k++) begin
			warn_d[k]  = !analog_sel[k+NDED] & (uv_filt[k+NDED] | ov_filt[k+NDED]);
			logic_d[k] = !analog_sel[k+NDED] & DUAL_FUNCTION_LOGIC_I[k];
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			fault_q <= '0;
			uvf_q   <= '0;
			ovf_q   <= '0;
			warn_q  <= '0;
			logic_q <= '0;
		end else begin
			fault_q <= fault_d;
			uvf_q   <= uv_filt;
			ovf_q   <= ov_filt;
			warn_q  <= warn_d;
			logic_q <= logic_d;
		end
	end

	assign FAULT_O             = fault_q;
	assign UNDERVOLTAGE_FLAG_O = uvf_q;
	assign OVERVOLTAGE_FLAG_O  = ovf_q;
	assign WARNING_O           = warn_q;
	assign LOGIC_INPUT_O       = logic_q;

	// APB decode
	assign setup   = PSEL_I && !PENABLE_I;
	assign access  = PSEL_I && PENABLE_I && pready_q;
	assign cfg_hit = (PADDR_I < supply_fault_pkg::ADDR_CFG_END) && (PADDR_I[1:0] == 2'h0);
	assign cfg_idx = PADDR_I[5:2];
	assign addr_known = cfg_hit
		|| (PADDR_I == supply_fault_pkg::ADDR_FAULT)
		|| (PADDR_I == supply_fault_pkg::ADDR_UV)
		|| (PADDR_I == supply_fault_pkg::ADDR_OV)
		|| (PADDR_I == supply_fault_pkg::ADDR_WARN)
		|| (PADDR_I == supply_fault_pkg::ADDR_LOGIC);

	always_comb begin
		for (int k = 0; k < NCH; k++) begin
			cfg_d[k] = cfg_q[k];
		end
		prdata_d  = prdata_q;
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		if (setup) begin
			pready_d = 1'b1;
			prdata_d = 32'h0000_0000;
			if (cfg_hit) begin
				prdata_d = cfg_q[cfg_idx];
			end else begin
				unique case (PADDR_I)
					supply_fault_pkg::ADDR_FAULT: prdata_d = {22'h0, fault_q};
					supply_fault_pkg::ADDR_UV:    prdata_d = {22'h0, uvf_q};
					supply_fault_pkg::ADDR_OV:    prdata_d = {22'h0, ovf_q};
					supply_fault_pkg::ADDR_WARN:  prdata_d = {27'h0, warn_q};
					supply_fault_pkg::ADDR_LOGIC: prdata_d = {27'h0, logic_q};
					default:                      pslverr_d = 1'b1;
				endcase
			end
		end
		if (access && PWRITE_I && cfg_hit) begin
			for (int b = 0; b < 4; b++) begin
				if (PSTRB_I[b]) begin
					cfg_d[cfg_idx][b*8 +: 8] = PWDATA_I[b*8 +: 8] & supply_fault_pkg::CFG_MASK[b*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			for (int k = 0; k < NCH; k++) begin
				cfg_q[k] <= supply_fault_pkg::CFG_RESET;
			end
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			for (int k = 0; k < NCH; k++) begin
				cfg_q[k] <= cfg_d[k];
			end
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign PRDATA_O  = prdata_q;
	assign PREADY_O  = pready_q;
	assign PSLVERR_O = pslverr_q;

	property p_logic_excl;
		@(posedge CLK_I) disable iff (RST_I)
		analog_sel[NCH-1:NDED] != '0 |=> (LOGIC_INPUT_O & $past(analog_sel[NCH-1:NDED])) == '0;
	endproperty
	a_logic_excl: assert property (p_logic_excl) else $error("Logic input active on analog pin");

	property p_warn_excl;
		@(posedge CLK_I) disable iff (RST_I)
		1'b1 |=> (WARNING_O & $past(analog_sel[NCH-1:NDED])) == '0;
	endproperty
	a_warn_excl: assert property (p_warn_excl) else $error("Warning from analog-mode pin");

	property p_vh_range;
		@(posedge CLK_I) disable iff (RST_I)
		g_ch[0].rng_sel[1] == 1'b1;
	endproperty
	a_vh_range: assert property (p_vh_range) else $error("High voltage input left its ranges");

	sequence s_setup;
		PSEL_I && !PENABLE_I;
	endsequence
	property p_apb_answer;
		@(posedge CLK_I) disable iff (RST_I)
		s_setup |=> PREADY_O ##1 !PREADY_O;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("APB answer not one cycle after setup");

	// Bus answer by address
	sequence s_good_addr;
		PSEL_I && !PENABLE_I && addr_known;
	endsequence
	sequence s_bad_addr;
		PSEL_I && !PENABLE_I && !addr_known;
	endsequence

	property p_apb_refuse;
		@(posedge CLK_I) disable iff (RST_I)
		s_bad_addr |=> PREADY_O && PSLVERR_O && (PRDATA_O == 32'h0000_0000);
	endproperty
	a_apb_refuse: assert property (p_apb_refuse) else $error("Unmapped address accepted");

	property p_apb_accept;
		@(posedge CLK_I) disable iff (RST_I)
		s_good_addr |=> PREADY_O && !PSLVERR_O;
	endproperty
	a_apb_accept: assert property (p_apb_accept) else $error("Mapped address refused");

	property p_cfg_read;
		@(posedge CLK_I) disable iff (RST_I)
		s_good_addr ##0 cfg_hit |=> (PRDATA_O == $past(cfg_q[cfg_idx])) && (PRDATA_O[31:29] == 3'h0);
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("Config word read back wrong");

	// Output words against the filtered flags and logic pins, then channel setup
	property p_fault_or;
		@(posedge CLK_I) disable iff (RST_I)
		1'b1 |=> FAULT_O == ($past(analog_sel) & (UNDERVOLTAGE_FLAG_O | OVERVOLTAGE_FLAG_O));
	endproperty
	a_fault_or: assert property (p_fault_or) else $error("Fault not the union of flags");

	property p_warn_or;
		@(posedge CLK_I) disable iff (RST_I)
		1'b1 |=> WARNING_O == (~$past(analog_sel[NCH-1:NDED])
			& (UNDERVOLTAGE_FLAG_O[NCH-1:NDED] | OVERVOLTAGE_FLAG_O[NCH-1:NDED]));
	endproperty
	a_warn_or: assert property (p_warn_or) else $error("Warning not from logic-mode flags");

	property p_logic_follow;
		@(posedge CLK_I) disable iff (RST_I)
		1'b1 |=> LOGIC_INPUT_O == (~$past(analog_sel[NCH-1:NDED]) & $past(DUAL_FUNCTION_LOGIC_I));
	endproperty
	a_logic_follow: assert property (p_logic_follow) else $error("Logic input not passed");

	property p_dedicated;
		@(posedge CLK_I) disable iff (RST_I)
		analog_sel[NDED-1:0] == {NDED{1'b1}};
	endproperty
	a_dedicated: assert property (p_dedicated) else $error("Dedicated input not analog");

	property p_pos_clamp;
		@(posedge CLK_I) disable iff (RST_I)
		(g_ch[1].rng_sel != supply_fault_pkg::RANGE_HIGH_HV)
			&& (g_ch[2].rng_sel != supply_fault_pkg::RANGE_HIGH_HV)
			&& (g_ch[3].rng_sel != supply_fault_pkg::RANGE_HIGH_HV)
			&& (g_ch[4].rng_sel != supply_fault_pkg::RANGE_HIGH_HV);
	endproperty
	a_pos_clamp: assert property (p_pos_clamp) else $error("Supply input in top range");
endmodule // supply_fault_monitor
`default_nettype wire

// ---- dv/supply_rail_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module supply_rail_model (
	// Clock
	input  wire logic        clk_i,
	// Rails and logic pins
	output logic      [15:0] hv_mv_o,
	output logic      [63:0] pos_mv_o,
	output logic      [79:0] dual_mv_o,
	output logic      [4:0]  dual_logic_o
);
	logic [15:0] rail_q [10];
	logic [4:0]  pin_q;

	// Levels change just after an edge
	task automatic set_mv(input int ch, input logic [15:0] mv);
		@(posedge clk_i);
		rail_q[ch] <= mv;
	endtask

	task automatic set_pin(input int j, input logic v);
		@(posedge clk_i);
		pin_q[j] <= v;
	endtask

	initial begin
		for (int k = 0; k < 10; k++)
			rail_q[k] = 16'h0000;
		pin_q = 5'h00;
	end

	always_comb begin
		hv_mv_o = rail_q[0];
		for (int k = 0; k < 4; k++)
			pos_mv_o[16*k +: 16] = rail_q[k+1];
		for (int j = 0; j < 5; j++)
			dual_mv_o[16*j +: 16] = rail_q[j+5];
		dual_logic_o = pin_q;
	end
endmodule // supply_rail_model
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [15:0] hv_mv;
	logic [63:0] pos_mv;
	logic [79:0] dual_mv;
	logic [4:0]  dual_logic, warn, logic_in;
	logic [9:0]  fault, uvf, ovf;
	int          error_cnt, tests_run;
	int          cycles = 0;

	supply_fault_monitor supply_fault_monitor_i (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.HIGH_VOLTAGE_INPUT_MV_I(hv_mv), .POSITIVE_SUPPLY_INPUT_MV_I(pos_mv),
		.DUAL_FUNCTION_INPUT_MV_I(dual_mv), .DUAL_FUNCTION_LOGIC_I(dual_logic),
		.FAULT_O(fault), .UNDERVOLTAGE_FLAG_O(uvf), .OVERVOLTAGE_FLAG_O(ovf),
		.WARNING_O(warn), .LOGIC_INPUT_O(logic_in));

	supply_rail_model supply_rail_model_i (.clk_i(clk), .hv_mv_o(hv_mv), .pos_mv_o(pos_mv),
		.dual_mv_o(dual_mv), .dual_logic_o(dual_logic));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic report_and_stop;
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			report_and_stop;
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [31:0] b(input logic x);
		return {31'h0, x};
	endfunction

	function automatic logic [31:0] cfg(input logic [7:0] uv, ov, input logic [4:0] hy,
		input logic [1:0] md, rg, input logic [2:0] fl, input logic an);
		return {3'h0, an, fl, rg, md, hy, ov, uv};
	endfunction

	// One APB transfer, held until pready is seen
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wcfg(input int ch, input logic [31:0] w);
		apb(1'b1, 12'(4*ch), w, 4'hf);
		chk("cfg write err", b(err), 32'h0);
	endtask

	task automatic rail(input int ch, input logic [15:0] mv);
		supply_rail_model_i.set_mv(ch, mv);
		repeat (6) @(posedge clk);
	endtask

	initial begin
		{psel, penable, pwrite, error_cnt, tests_run} = '0;
		{paddr, pwdata, pstrb} = '0;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// Reset values and register map
		apb(1'b0, supply_fault_pkg::ADDR_CFG_BASE, 32'h0, 4'hf);
		chk("cfg0 reset", rd, supply_fault_pkg::CFG_RESET);
		apb(1'b0, supply_fault_pkg::ADDR_FAULT, 32'h0, 4'hf);
		chk("fault reset", rd, 32'h0);
		apb(1'b0, 12'h100, 32'h0, 4'hf);
		chk("unmapped err", b(err), 32'h1);
		wcfg(8, 32'hffff_ffff);
		apb(1'b0, 12'h020, 32'h0, 4'hf);
		chk("cfg8 mask", rd, supply_fault_pkg::CFG_MASK);
		wcfg(8, 32'h0);
		apb(1'b1, 12'h024, 32'hffff_ffff, 4'h1);
		apb(1'b0, 12'h024, 32'h0, 4'hf);
		chk("cfg9 strobe", rd, 32'h0000_00ff);
		apb(1'b1, supply_fault_pkg::ADDR_FAULT, 32'hffff_ffff, 4'hf);
		chk("status write err", b(err), 32'h0);
		// Undervoltage, threshold 4256, hysteresis 425
		rail(1, 16'd5000);
		wcfg(1, cfg(8'h80, 8'h00, 5'h1f, supply_fault_pkg::MODE_UV, 2'h2, 3'h0, 1'b0));
		rail(1, 16'd4256);
		chk("uv at th", b(fault[1]), 32'h0);
		rail(1, 16'd4255);
		chk("uv set", b(uvf[1]), 32'h1);
		rail(1, 16'd4681);
		chk("uv hold", b(fault[1]), 32'h1);
		rail(1, 16'd4682);
		chk("uv clear", b(fault[1]), 32'h0);
		rail(1, 16'd4000);
		wcfg(1, 32'h0);
		repeat (6) @(posedge clk);
		chk("mode off", b(fault[1]), 32'h0);
		// Overvoltage, threshold 1689, hysteresis 109
		rail(2, 16'd1500);
		wcfg(2, cfg(8'h00, 8'h40, 5'h10, supply_fault_pkg::MODE_OV, 2'h1, 3'h0, 1'b0));
		rail(2, 16'd1689);
		chk("ov at th", b(ovf[2]), 32'h0);
		rail(2, 16'd1690);
		chk("ov set", b(fault[2]), 32'h1);
		rail(2, 16'd1580);
		chk("ov hold", b(ovf[2]), 32'h1);
		rail(2, 16'd1579);
		chk("ov clear", b(ovf[2]), 32'h0);
		// Window on analog dual input, 774..1176
		supply_rail_model_i.set_pin(0, 1'b1);
		rail(5, 16'd900);
		wcfg(5, cfg(8'h40, 8'hc0, 5'h00, supply_fault_pkg::MODE_WINDOW, 2'h3, 3'h0, 1'b1));
		rail(5, 16'd773);
		chk("win uv", {30'h0, uvf[5], fault[5]}, 32'h3);
		chk("analog no logic", b(logic_in[0]), 32'h0);
		rail(5, 16'd900);
		chk("win ok", b(fault[5]), 32'h0);
		rail(5, 16'd1177);
		chk("win ov", {30'h0, ovf[5], fault[5]}, 32'h3);
		// Logic mode: warning on mapped rail, primary range
		supply_rail_model_i.set_pin(1, 1'b1);
		wcfg(6, cfg(8'hff, 8'h00, 5'h00, supply_fault_pkg::MODE_UV, 2'h0, 3'h0, 1'b0));
		repeat (6) @(posedge clk);
		chk("logic pin", b(logic_in[1]), 32'h1);
		chk("warning", b(warn[1]), 32'h1);
		chk("no fault", b(fault[6]), 32'h0);
		apb(1'b0, supply_fault_pkg::ADDR_WARN, 32'h0, 4'hf);
		chk("warn read", rd, 32'h2);
		// High voltage input ranges
		rail(0, 16'd10000);
		wcfg(0, cfg(8'h80, 8'h00, 5'h00, supply_fault_pkg::MODE_UV, 2'h0, 3'h0, 1'b0));
		repeat (6) @(posedge clk);
		chk("hv low rng", b(fault[0]), 32'h0);
		wcfg(0, cfg(8'h80, 8'h00, 5'h00, supply_fault_pkg::MODE_UV, 2'h1, 3'h0, 1'b0));
		repeat (6) @(posedge clk);
		chk("hv high rng", b(fault[0]), 32'h1);
		// Glitch filter, 100 cycles
		rail(3, 16'd5000);
		wcfg(3, cfg(8'h80, 8'h00, 5'h00, supply_fault_pkg::MODE_UV, 2'h2, 3'h1, 1'b0));
		repeat (110) @(posedge clk);
		supply_rail_model_i.set_mv(3, 16'd4000);
		repeat (50) @(posedge clk);
		supply_rail_model_i.set_mv(3, 16'd5000);
		repeat (150) @(posedge clk);
		chk("pulse dropped", b(fault[3]), 32'h0);
		supply_rail_model_i.set_mv(3, 16'd4000);
		repeat (99) @(posedge clk);
		chk("delay early", b(fault[3]), 32'h0);
		repeat (6) @(posedge clk);
		chk("delay late", b(fault[3]), 32'h1);
		report_and_stop;
	end
endmodule // tb
`default_nettype wire
